// ---- inc/pic_pkg.sv ----
// Package for the prioritized interrupt controller.
`default_nettype none
package pic_pkg;
  localparam int NUM_SRC = 24;
  localparam int LVL_W = 2;
  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_MID = 2'h2;
  localparam logic [1:0] LVL_HIGH = 2'h3;
  localparam logic GIE_RESET = 1'h0;
  localparam int VEC_W = 5;
  localparam logic [15:0] VEC_BASE = 16'h000A;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam logic [15:0] VEC_WDT = 16'h0004;
  typedef struct packed {
    logic set_en;
    logic clr_en;
    logic di_instr;
    logic trap_instr;
    logic illegal_trap;
  } pic_ctl_t;
  typedef struct packed {
    logic valid;
    logic [4:0] index;
    logic [15:0] vector;
  } pic_grant_t;
endpackage : pic_pkg
`default_nettype wire

// ---- core/pic_top.sv ----
// Prioritized interrupt controller with request capture and arbitration.
`timescale 1ns/1ps
`default_nettype none
module pic_top #(
  parameter int NSRC = pic_pkg::NUM_SRC
) (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RST_I,
  // Sources and level programming.
  input wire logic [NSRC-1:0] SRC_PULSE_I,
  input wire logic [2*NSRC-1:0] SRC_LEVEL_I,
  // Software clear of request bits, one-cycle strobe with mask.
  input wire logic REQ_CLR_I,
  input wire logic [NSRC-1:0] REQ_CLR_MASK_I,
  // Global enable control and CPU events.
  input wire pic_pkg::pic_ctl_t CTL_I,
  // Watchdog interrupt.
  input wire logic WDT_IRQ_I,
  input wire logic WDT_IRQ_EN_I,
  // CPU acknowledge.
  input wire logic ACK_I,
  // Outputs to the CPU.
  output logic GIE_O,
  output logic [NSRC-1:0] PENDING_O,
  output pic_pkg::pic_grant_t GRANT_O,
  output logic WDT_REQ_O
);
  // The grant index is five bits wide, so no more than 32 sources fit.
  if (NSRC < 1 || NSRC > 32)
  begin : g_nsrc_check
    $error("NSRC out of range");
  end

  logic gie_reg;
  logic [NSRC-1:0] req_reg;
  logic wdt_reg;
  pic_pkg::pic_grant_t grant_reg;
  pic_pkg::pic_grant_t grant_next;
  logic [NSRC-1:0] req_next;
  logic grant_is_wdt;

  function automatic logic [1:0] lvl_of(input logic [2*NSRC-1:0] l,
                                        input int i);
    lvl_of = l[2*i+:2];
  endfunction : lvl_of

  // Global enable; every clear source beats set_en, so any clear wins.
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      gie_reg <= pic_pkg::GIE_RESET;
    end
    else if (CTL_I.di_instr || ACK_I || CTL_I.trap_instr ||
             CTL_I.illegal_trap)
    begin
      gie_reg <= 1'b0;
    end
    else if (CTL_I.clr_en)
    begin
      gie_reg <= 1'b0;
    end
    else if (CTL_I.set_en)
    begin
      gie_reg <= 1'b1;
    end
  end

  // Request bits: capture pulse, clear on ack or software, set wins.
  always_comb
  begin
    req_next = req_reg;
    if (REQ_CLR_I)
    begin
      req_next = req_next & ~REQ_CLR_MASK_I;
    end
    // The acknowledge belongs to the grant on show, not to a late watchdog.
    if (ACK_I && grant_reg.valid && !grant_is_wdt)
    begin
      req_next[grant_reg.index] = 1'b0;
    end
    req_next = req_next | SRC_PULSE_I;
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      req_reg <= '0;
    end
    else
    begin
      req_reg <= req_next;
    end
  end

  // Watchdog request sits above all levels when enabled.
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      wdt_reg <= 1'b0;
    end
    else if (WDT_IRQ_I && WDT_IRQ_EN_I)
    begin
      wdt_reg <= 1'b1;
    end
    else if (ACK_I && grant_reg.valid && grant_is_wdt)
    begin
      wdt_reg <= 1'b0;
    end
  end

  // Arbitration: highest level first, lowest index (lowest vector) next.
  always_comb
  begin
    logic [1:0] best;
    best = pic_pkg::LVL_OFF;
    grant_next = '0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (req_reg[i] && gie_reg &&
          lvl_of(SRC_LEVEL_I, i) != pic_pkg::LVL_OFF &&
          lvl_of(SRC_LEVEL_I, i) >= best)
      begin
        best = lvl_of(SRC_LEVEL_I, i);
        grant_next.valid = 1'b1;
        grant_next.index = i[4:0];
        grant_next.vector = pic_pkg::VEC_BASE +
                            16'(i) * pic_pkg::VEC_STEP;
      end
    end
    if (wdt_reg)
    begin
      grant_next.valid = 1'b1;
      grant_next.index = 5'h00;
      grant_next.vector = pic_pkg::VEC_WDT;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      grant_reg <= '0;
    end
    else if (ACK_I)
    begin
      grant_reg <= '0;
    end
    else
    begin
      grant_reg <= grant_next;
    end
  end

  assign GIE_O = gie_reg;
  assign PENDING_O = req_reg;
  assign GRANT_O = grant_reg;
  assign WDT_REQ_O = wdt_reg;
  assign grant_is_wdt = grant_reg.vector == pic_pkg::VEC_WDT;

  a_ack_clears_gie: assert property (@(posedge CLK_I)
    disable iff (RST_I) ACK_I |=> !gie_reg)
    else $error("ack left enable set");
  a_di_clears_gie: assert property (@(posedge CLK_I)
    disable iff (RST_I) CTL_I.di_instr |=> !gie_reg)
    else $error("di left enable set");
  a_set_gie: assert property (@(posedge CLK_I)
    disable iff (RST_I)
    CTL_I.set_en && !CTL_I.clr_en && !CTL_I.di_instr && !ACK_I &&
    !CTL_I.trap_instr && !CTL_I.illegal_trap |=> gie_reg)
    else $error("enable not set");
  a_clr_gie: assert property (@(posedge CLK_I)
    disable iff (RST_I) CTL_I.clr_en |=> !gie_reg)
    else $error("enable not cleared");
  a_trap_gie: assert property (@(posedge CLK_I)
    disable iff (RST_I)
    CTL_I.trap_instr || CTL_I.illegal_trap |=> !gie_reg)
    else $error("trap left enable set");
  a_pulse_caught: assert property (@(posedge CLK_I)
    disable iff (RST_I) SRC_PULSE_I[0] |=> req_reg[0])
    else $error("pulse lost");
  a_sw_clear: assert property (@(posedge CLK_I)
    disable iff (RST_I)
    REQ_CLR_I && REQ_CLR_MASK_I[0] && !SRC_PULSE_I[0] |=> !req_reg[0])
    else $error("software clear failed");
  a_grant_gated: assert property (@(posedge CLK_I)
    disable iff (RST_I)
    grant_reg.valid && !$past(wdt_reg) |-> $past(gie_reg))
    else $error("grant while disabled");
  a_wdt_wins: assert property (@(posedge CLK_I)
    disable iff (RST_I)
    $past(wdt_reg) && !$past(ACK_I) |->
    grant_reg.vector == pic_pkg::VEC_WDT)
    else $error("watchdog lost arbitration");
  a_level_order: assert property (@(posedge CLK_I)
    disable iff (RST_I)
    grant_reg.valid && !$past(wdt_reg) && $past(req_reg[0]) &&
    lvl_of($past(SRC_LEVEL_I), 0) == pic_pkg::LVL_HIGH |->
    grant_reg.index == 5'h00)
    else $error("order wrong");
  a_ack_clears_req: assert property (@(posedge CLK_I)
    disable iff (RST_I)
    ACK_I && grant_reg.valid && !grant_is_wdt &&
    !SRC_PULSE_I[grant_reg.index] |=>
    !req_reg[$past(grant_reg.index)])
    else $error("acknowledged request left pending");
  a_off_never_granted: assert property (@(posedge CLK_I)
    disable iff (RST_I)
    grant_reg.valid && !$past(wdt_reg) |->
    lvl_of($past(SRC_LEVEL_I), grant_reg.index) != pic_pkg::LVL_OFF)
    else $error("disabled source granted");
  a_vector_map: assert property (@(posedge CLK_I)
    disable iff (RST_I)
    grant_reg.valid && !grant_is_wdt |->
    grant_reg.vector == pic_pkg::VEC_BASE +
    16'(grant_reg.index) * pic_pkg::VEC_STEP)
    else $error("vector does not match index");
endmodule : pic_top
`default_nettype wire

// ---- dv/pic_cpu_model.sv ----
// Behavioural CPU core that acknowledges granted interrupt requests.
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Permission to service and the grant shown by the controller.
  input wire logic en_i,
  input wire pic_pkg::pic_grant_t grant_i,
  // Acknowledge pulse.
  output logic ack_o
);
  // A low en_i models a core that is busy and answers late.
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= en_i && grant_i.valid && !ack_o;
endmodule : pic_cpu_model
`default_nettype wire

// ---- dv/tb_pic_top.sv ----
// Self-checking testbench for the interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module tb_pic_top;
  logic CLK_I = 0, RST_I = 1, REQ_CLR_I = 0, WDT_IRQ_I = 0, WDT_IRQ_EN_I = 0;
  logic cpu_en = 0, ACK_I, GIE_O, WDT_REQ_O;
  logic [23:0] SRC_PULSE_I = '0, REQ_CLR_MASK_I = '0, PENDING_O;
  logic [47:0] SRC_LEVEL_I = '0;
  pic_pkg::pic_ctl_t CTL_I = '0;
  pic_pkg::pic_grant_t GRANT_O;
  int bad_count = 0, samples_checked = 0;
  always #2.5 CLK_I = ~CLK_I;
  pic_top #(.NSRC(24)) u_dut (.CLK_I, .RST_I, .SRC_PULSE_I, .SRC_LEVEL_I,
    .REQ_CLR_I, .REQ_CLR_MASK_I, .CTL_I, .WDT_IRQ_I, .WDT_IRQ_EN_I, .ACK_I,
    .GIE_O, .PENDING_O, .GRANT_O, .WDT_REQ_O);
  pic_cpu_model u_cpu (.clk_i(CLK_I), .rst_i(RST_I), .en_i(cpu_en),
    .grant_i(GRANT_O), .ack_o(ACK_I));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask : tick
  task ctl(input logic [4:0] v);
    @(posedge CLK_I);
    CTL_I <= v;
    @(posedge CLK_I);
    CTL_I <= '0;
    #1;
  endtask : ctl
  // Every source pulse lasts exactly one clock.
  task drv(input logic [23:0] p, input logic [23:0] c, input logic w);
    @(posedge CLK_I);
    SRC_PULSE_I <= p;
    // Clears go by mask alone, never by writing back a read value.
    REQ_CLR_MASK_I <= c;
    REQ_CLR_I <= |c;
    WDT_IRQ_I <= w;
    @(posedge CLK_I);
    {SRC_PULSE_I, REQ_CLR_MASK_I, REQ_CLR_I, WDT_IRQ_I} <= '0;
    #1;
  endtask : drv
  task t_enable;
    chk(GIE_O, 0);
    ctl(5'h10);
    chk(GIE_O, 1);
    ctl(5'h08);
    chk(GIE_O, 0);
    for (int k = 1; k < 4; k++)
    begin
      ctl(5'h10);
      chk(GIE_O, 1);
      ctl(5'h08 >> k);
      chk(GIE_O, 0);
    end
    ctl(5'h10);
    @(posedge CLK_I);
    RST_I <= 1;
    tick(1);
    chk(GIE_O, 0);
    @(posedge CLK_I);
    RST_I <= 0;
    tick(1);
    $display("t_enable done");
  endtask : t_enable
  task t_prio;
    SRC_LEVEL_I <= 48'h300C40;
    drv(24'h00042A, '0, 0);
    chk(PENDING_O, 24'h42A);
    tick(1);
    chk(GRANT_O.valid, 0);
    ctl(5'h10);
    tick(1);
    chk(GRANT_O, {1'b1, 5'h05, 16'h0014});
    cpu_en <= 1;
    tick(3);
    chk(GIE_O, 0);
    chk(PENDING_O, 24'h40A);
    ctl(5'h10);
    tick(4);
    chk(PENDING_O, 24'h00A);
    ctl(5'h10);
    tick(4);
    chk(PENDING_O, 24'h002);
    cpu_en <= 0;
    ctl(5'h10);
    tick(2);
    chk(GRANT_O.valid, 0);
    chk(GIE_O, 1);
    ctl(5'h08);
    $display("t_prio done");
  endtask : t_prio
  task t_clear;
    drv(24'h000004, 24'h000006, 0);
    chk(PENDING_O, 24'h004);
    drv('0, 24'hFFFFFF, 0);
    chk(PENDING_O, 24'h000);
    $display("t_clear done");
  endtask : t_clear
  task t_wdt;
    SRC_LEVEL_I <= 48'h000000000003;
    WDT_IRQ_EN_I <= 1;
    ctl(5'h10);
    drv(24'h000001, '0, 1);
    chk(WDT_REQ_O, 1);
    tick(1);
    chk(GRANT_O, {1'b1, 5'h00, 16'h0004});
    cpu_en <= 1;
    tick(3);
    chk(WDT_REQ_O, 0);
    chk(PENDING_O, 24'h001);
    chk(GIE_O, 0);
    ctl(5'h10);
    tick(1);
    chk(GRANT_O, {1'b1, 5'h00, 16'h000A});
    tick(3);
    chk(PENDING_O, 24'h000);
    $display("t_wdt done");
  endtask : t_wdt
  task final_report;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (2) @(posedge CLK_I);
    RST_I <= 0;
    tick(1);
    t_enable;
    t_prio;
    t_clear;
    t_wdt;
    final_report;
  end
  // The tests need well under a thousand cycles.
  initial
  begin
    #5000;
    bad_count++;
    final_report;
  end
endmodule : tb_pic_top
`default_nettype wire
